// *** rtl/keyed_divider_regs.svh ***
`ifndef KEYED_DIVIDER_REGS_SVH
`define KEYED_DIVIDER_REGS_SVH

// ----------------------------------------
// widths and divisor range
// ----------------------------------------
`define KD_CODE_W 4
`define KD_DIV_MIN 1
`define KD_DIV_MAX 16
`define KD_KEYS 16

// ----------------------------------------
// timing: clock rate and scan dwell
// ----------------------------------------
`define KD_CLK_MHZ 10
// dwell per keypad row in microseconds
`define KD_ROW_DWELL_US 1000
// cycles per row dwell, derived from time and clock rate
`define KD_ROW_DWELL_CYCLES (`KD_ROW_DWELL_US * `KD_CLK_MHZ)
// full scans that must agree before a key is accepted
`define KD_DEBOUNCE_SCANS 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define KD_CODE_RESET 4'h0
`define KD_ROW_RESET 2'h0

`endif

// *** rtl/keyed_divider_pkg.sv ***
package keyed_divider_pkg;

  // ----------------------------------------
  // debounce states, gray along idle-bounce-held-release
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_BOUNCE = 2'h1,
    ST_HELD = 2'h3,
    ST_RELEASE = 2'h2
  } debounce_state_t;

  typedef logic [3:0] key_code_t;

endpackage

// *** rtl/sync_two_ff.sv ***
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // ----------------------------------------
  // two flops, the first read only by the second
  // ----------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// *** rtl/keyed_divider.sv ***
// How it works
// - the input frequency is divided by a divisor n from 1 to 16 picked by a key.
// - each key is encoded as 16 minus its label, so key 16 gives 0, key 1 gives 15, key 5 gives 1011.
// - the keypad matrix is scanned, a pressed key is found and debounced before it is encoded.
// - the code of the last pressed key is held in a register and stays on the code outputs until another key.
// - the divider feedback drives the code output enable, so the code floats in one feedback state.
// - the phase-control input of each stage reads zero whenever the code outputs float.
// - an active one on a code bit inverts the clock passed from that stage to the next.
// - a zero or floating code bit passes the stage clock with no inversion.
// - the output and the feedback change state once every n/2 input periods.
// - on each feedback transition every stage with a one flips phase, adding one count of weight 1 to 8.
// - the divided output has equal high and low times for every divisor, odd or even.
`include "keyed_divider_regs.svh"

module keyed_divider #(
  parameter int ROW_DWELL_CYCLES = `KD_ROW_DWELL_CYCLES,
  parameter int DEBOUNCE_SCANS = `KD_DEBOUNCE_SCANS
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic freq_in,
  input wire logic [3:0] col_n_in,
  output logic [3:0] row_n_out,
  output keyed_divider_pkg::key_code_t code_out,
  output logic code_oe_out,
  output logic key_strobe_out,
  output logic div_out
);
  import keyed_divider_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (ROW_DWELL_CYCLES < 4)
  begin : g_bad_dwell
    $error("row dwell must cover the column synchroniser delay");
  end
  if (DEBOUNCE_SCANS < 2 || DEBOUNCE_SCANS > 15)
  begin : g_bad_deb
    $error("debounce scan count must be 2 to 15");
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // lowest pulled-low column, columns are active low
  function automatic logic [1:0] first_low(input logic [3:0] cols_n);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (!cols_n[i])
      begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [3:0] cols_s;
  logic freq_s;
  logic freq_prev_q;
  logic [$clog2(ROW_DWELL_CYCLES)-1:0] dwell_q;
  logic row_tick;
  logic [1:0] row_q;
  logic row_hit;
  logic scan_done;
  logic scan_hit;
  logic [3:0] scan_key;
  logic hit_q;
  logic [3:0] hit_key_q;
  debounce_state_t state_q;
  debounce_state_t state_d;
  logic [3:0] cand_q;
  logic [3:0] agree_q;
  logic accept;
  key_code_t code_q;
  logic fb_q;
  logic [3:0] count_q;
  logic half_edge;
  logic fb_flip;
  logic [3:0] xor_in;
  logic [3:0] xor_next;
  logic [3:0] phase_flip;

  // ----------------------------------------
  // synchronisers for the pins
  // ----------------------------------------
  sync_two_ff #(.WIDTH(4)) u_col_sync (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .async_in(col_n_in),
    .sync_out(cols_s)
  );

  sync_two_ff #(.WIDTH(1)) u_freq_sync (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .async_in(freq_in),
    .sync_out(freq_s)
  );

  // ----------------------------------------
  // row dwell divider and row sequencing
  // ----------------------------------------
  assign row_tick = (dwell_q == ($bits(dwell_q))'(ROW_DWELL_CYCLES - 1));
  assign row_hit = (cols_s != 4'hF);
  assign scan_done = row_tick && (row_q == 2'h3);
  assign scan_hit = hit_q || row_hit;
  // position row*4+col; the keys are laid out so this already equals 16 - label
  assign scan_key = hit_q ? hit_key_q : {row_q, first_low(cols_s)};
  // one row pulled low at a time, the rest released high
  assign row_n_out = ~(4'h1 << row_q);

  // scan the matrix
  // columns are read only at the end of a dwell so the sync delay has long settled
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      dwell_q <= '0;
      row_q <= `KD_ROW_RESET;
      hit_q <= 1'b0;
      hit_key_q <= 4'h0;
    end
    else
    begin
      dwell_q <= row_tick ? '0 : dwell_q + 1'b1;
      if (row_tick)
      begin
        row_q <= row_q + 2'h1;
        hit_q <= scan_done ? 1'b0 : scan_hit;
        hit_key_q <= scan_done ? 4'h0 : scan_key;
      end
    end
  end

  // ----------------------------------------
  // debounce state machine, one step per full scan
  // ----------------------------------------
  // debounce the key
  assign accept = scan_done && (state_q == ST_BOUNCE) && scan_hit && (scan_key == cand_q)
    && (agree_q == 4'(DEBOUNCE_SCANS - 1));

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        state_d = scan_hit ? ST_BOUNCE : ST_IDLE;
      ST_BOUNCE:
        if (!scan_hit)
        begin
          state_d = ST_IDLE;
        end
        else if (accept)
        begin
          state_d = ST_HELD;
        end
      ST_HELD:
        state_d = scan_hit ? ST_HELD : ST_RELEASE;
      ST_RELEASE:
        state_d = scan_hit ? ST_HELD : ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // a held key is accepted once; a second key needs a clean release first
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      state_q <= ST_IDLE;
      cand_q <= 4'h0;
      agree_q <= 4'h0;
    end
    else if (scan_done)
    begin
      state_q <= state_d;
      cand_q <= scan_key;
      agree_q <= (scan_hit && scan_key == cand_q && state_q == ST_BOUNCE) ? agree_q + 4'h1 : 4'h1;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      code_q <= `KD_CODE_RESET;
      key_strobe_out <= 1'b0;
    end
    else
    begin
      key_strobe_out <= accept;
      if (accept)
      begin
        code_q <= cand_q;
      end
    end
  end

  // ----------------------------------------
  // phase-controlled counter
  // ----------------------------------------
  // feedback gates the code outputs
  assign code_oe_out = ~fb_q;
  assign code_out = code_q;
  assign xor_in = code_q & {4{code_oe_out}};
  // gate input after the coming feedback change
  assign xor_next = code_q & {4{fb_q}};
  // stages whose phase inverts at the transition add their weight
  assign phase_flip = xor_in ^ xor_next;
  // both input edges count, each is half an input period
  assign half_edge = freq_s ^ freq_prev_q;
  // n half periods from the reload to the carry
  assign fb_flip = half_edge && (count_q == 4'hF);

  // reload at every feedback change, so both halves last n half periods
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      freq_prev_q <= 1'b0;
      count_q <= 4'h0;
      fb_q <= 1'b0;
    end
    else
    begin
      freq_prev_q <= freq_s;
      if (fb_flip)
      begin
        count_q <= phase_flip;
        fb_q <= ~fb_q;
      end
      else if (half_edge)
      begin
        count_q <= count_q + 4'h1;
      end
    end
  end

  assign div_out = fb_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [4:0] span_q;
  logic [3:0] load_q;

  // half periods since the last feedback change and the weight loaded then
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      span_q <= 5'h0;
      load_q <= 4'h0;
    end
    else if (fb_flip)
    begin
      span_q <= 5'h0;
      load_q <= phase_flip;
    end
    else if (half_edge)
    begin
      span_q <= span_q + 5'h1;
    end
  end

  sequence press_agreed;
    scan_done && state_q == ST_BOUNCE && scan_hit && scan_key == cand_q;
  endsequence

  sequence code_taken;
    key_strobe_out ##0 code_out == $past(cand_q, 1);
  endsequence

  half_span_a: assert property (@(posedge clock_in) disable iff (srst_in)
    fb_flip |-> (span_q + 5'h1) == (5'h10 - {1'b0, load_q}))
    else $error("feedback changed after wrong number of half periods");

  out_quiet_a: assert property (@(posedge clock_in) disable iff (srst_in)
    !half_edge |=> $stable(div_out))
    else $error("divided output moved without an input edge");

  float_high_a: assert property (@(posedge clock_in) disable iff (srst_in)
    $rose(div_out) |-> !code_oe_out ##1 (!code_oe_out || $fell(div_out)))
    else $error("code outputs not floated while feedback high");

  float_zero_a: assert property (@(posedge clock_in) disable iff (srst_in)
    !code_oe_out |-> xor_in == 4'h0)
    else $error("phase input not zero while code floats");

  reload_weight_a: assert property (@(posedge clock_in) disable iff (srst_in)
    fb_flip |=> count_q == $past(code_q))
    else $error("reload weight differs from latched code");

  code_hold_a: assert property (@(posedge clock_in) disable iff (srst_in)
    !key_strobe_out ##1 !key_strobe_out |-> $stable(code_out))
    else $error("code changed without a key press");

  debounce_req_a: assert property (@(posedge clock_in) disable iff (srst_in)
    key_strobe_out |-> $past(state_q) == ST_BOUNCE && $past(agree_q) == 4'(DEBOUNCE_SCANS - 1))
    else $error("key accepted before debounce completed");

  code_encode_a: assert property (@(posedge clock_in) disable iff (srst_in)
    press_agreed and accept |=> code_taken)
    else $error("latched code is not the scanned key position");

  row_onehot_a: assert property (@(posedge clock_in) disable iff (srst_in)
    $onehot(~row_n_out))
    else $error("more than one keypad row driven");

  late_code_a: assert property (@(posedge clock_in) disable iff (srst_in)
    key_strobe_out && !fb_flip |=> load_q == $past(load_q))
    else $error("new code disturbed the running half period");

endmodule

// *** test/keypad_freq_model.sv ***
module keypad_freq_model (
  input wire logic clock_in,
  input wire logic [3:0] row_n_in,
  input wire logic [15:0] keys_in,
  input wire logic [3:0] half_in,
  output logic [3:0] col_n_out,
  output logic freq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  int r;
  logic [3:0] low;
  initial col_n_out = 4'hF;
  initial freq_out = 1'b0;
  // --------
  // keypad matrix
  // --------
  // a column is pulled high unless a pressed key joins it to a low row
  always @(posedge clock_in)
  begin
    low = 4'h0;
    for (r = 0; r < 4; r++)
      if (row_n_in[r] === 1'b0)
        low = low | keys_in[r*4 +: 4];
    col_n_out <= ~low;
  end
  // --------
  // input frequency source
  // --------
  // free-running square wave, half_in clock cycles per level
  always @(posedge clock_in)
  begin
    if (cnt + 1 >= half_in)
    begin
      cnt <= 0;
      freq_out <= ~freq_out;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

// *** test/keyed_divider_tb.sv ***
module keyed_divider_tb;
  import keyed_divider_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DWELL = 8;
  localparam int SCAN = 4 * DWELL;
  logic clock_in, srst_in, freq_in, code_oe_out, key_strobe_out, div_out, prev_f, prev_d, phase;
  logic [3:0] col_n_in, row_n_out, half;
  logic [15:0] keys;
  key_code_t code_out;
  int mismatches = 0, total_checks = 0, strobes = 0, edges = 0, cyc = 0;
  int q_e[$], q_c[$];
  logic [31:0] seed = 32'hE61B75BB;

  keyed_divider #(.ROW_DWELL_CYCLES(DWELL), .DEBOUNCE_SCANS(4)) dut (.clock_in(clock_in), .srst_in(srst_in),
    .freq_in(freq_in), .col_n_in(col_n_in), .row_n_out(row_n_out), .code_out(code_out),
    .code_oe_out(code_oe_out), .key_strobe_out(key_strobe_out), .div_out(div_out));
  keypad_freq_model model (.clock_in(clock_in), .row_n_in(row_n_out), .keys_in(keys), .half_in(half),
    .col_n_out(col_n_in), .freq_out(freq_in));

  // --------
  // helpers
  // --------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic tally(logic ok, string what, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (!ok)
    begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic check_code(string what, key_code_t e, key_code_t g);
    tally(g === e, what, e, g);
  endtask
  task automatic check_bit(string what, logic e, logic g);
    tally(g === e, what, e, g);
  endtask
  task automatic check_int(string what, int e, int g);
    tally(g == e, what, e, g);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // --------
  // clock and watchdog
  // --------
  initial
  begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  // the full key sweep needs well under this many cycles
  initial
  begin
    #(60000 * 100);
    mismatches++;
    test_done();
  end

  // --------
  // reference: input edges and cycles between output toggles
  // --------
  always @(posedge clock_in)
  begin
    prev_f <= freq_in;
    prev_d <= div_out;
    cyc = cyc + 1;
    if (freq_in !== prev_f)
      edges = edges + 1;
    if (key_strobe_out === 1'b1)
      strobes = strobes + 1;
    if (srst_in === 1'b1)
    begin
      edges = 0;
      cyc = 0;
      phase = 1'b0;
    end
    else if (div_out !== prev_d)
    begin
      phase = ~phase;
      q_e.push_back(edges);
      q_c.push_back(cyc);
      check_bit("divided output", phase, div_out);
      check_bit("code enable", ~phase, code_oe_out);
      edges = 0;
      cyc = 0;
    end
  end

  // --------
  // main sequence
  // --------
  initial
  begin
    int p, n, b, i, k, s0;
    srst_in = 1'b1;
    keys = 16'h0000;
    half = 4'h4;
    repeat (10) @(posedge clock_in);
    check_code("reset code", 4'h0, code_out);
    check_code("reset rows", 4'hE, row_n_out);
    check_bit("reset output", 1'b0, div_out);
    check_bit("reset enable", 1'b1, code_oe_out);
    srst_in <= 1'b0;
    $display("test reset done");
    b = rnd() % 16;
    // stride 7 visits all sixteen keys; half period of 4 or more keeps edges apart from the 3-cycle latency
    for (i = 0; i < 16; i++)
    begin
      p = (b + i * 7) % 16;
      n = 16 - p;
      half <= 4'(4 + rnd() % 4);
      s0 = strobes;
      keys <= 16'h0001 << p;
      k = 0;
      while (key_strobe_out !== 1'b1 && k < 600)
      begin
        @(posedge clock_in);
        k++;
      end
      check_code("key code", 4'(p), code_out);
      q_e.delete();
      q_c.delete();
      // a second key while the first is held must be ignored
      if (i == 0)
      begin
        keys <= keys | (16'h0001 << ((p + 3) % 16));
        repeat (6 * SCAN) @(posedge clock_in);
        check_code("held code", 4'(p), code_out);
      end
      keys <= 16'h0000;
      repeat (4 * SCAN + DWELL) @(posedge clock_in);
      check_int("strobe count", 1, strobes - s0);
      check_code("kept code", 4'(p), code_out);
      k = 0;
      while (q_e.size() < 5 && k < 3000)
      begin
        @(posedge clock_in);
        k++;
      end
      // the first two entries may still carry the old code: a toggle in the
      // strobe cycle races the queue clear, so only later halves are judged
      for (k = 2; k < 5; k++)
      begin
        check_int("edges per half", n, q_e[k]);
        check_int("cycles per half", n * half, q_c[k]);
      end
      $display("test key %0d divisor %0d done", p, n);
    end
    test_done();
  end
endmodule
